// [src/i2c_slave_regs.svh]
// Purpose: Register offsets, field positions and bus constants of the I2C slave port.
// Assumes: 32-bit APB data, one aligned word per register, byte addresses below 0x100.
// Notes:   Included by the top design file of the slave port, the checker and the bench.
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH

// Register byte offsets.
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_DATA        8'h08
`define OFF_TX0         8'h0C
`define OFF_TX1         8'h10

// Control register fields.
`define CTL_ENABLE      0
`define CTL_EVT_EN      1

// Status register fields.
`define ST_RX_READY     0
`define ST_TX_DONE      1
`define ST_TX_RESET     2
`define ST_ADDRESSED    3
`define ST_READ_DIR     4

// Reset values.
`define RST_TX_RESET    1'b1
`define RST_BYTE        8'h00
`define RST_WORD        32'h0000_0000

// Fixed bus address in its write form.
`define DEV_ADDR_WRITE  8'h6C

// Bit count of one byte on the bus.
`define BITS_PER_BYTE   4'h8

// Byte sent once the two-byte message is exhausted (line left released).
`define TX_FILL         8'hFF

// Transmit byte counter values.
`define TXC_NONE        2'h0
`define TXC_ONE         2'h1
`define TXC_TWO         2'h2

`endif

// [src/i2c_slave_pkg.sv]
// Purpose: Types shared by the I2C slave port modules.
// Assumes: Constants come from i2c_slave_regs.svh.
// Notes:   The core state is one packed struct, registered as a whole.
package i2c_slave_pkg;

	// Bus-side sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK,
		ST_IGNORE
	} seq_state_t;

	// Complete state of the slave core.
	typedef struct packed {
		seq_state_t  st;
		logic [3:0]  bitcnt;
		logic [7:0]  shreg;
		logic        rw;
		logic [1:0]  tx_cnt;
		logic        mack;
		logic        sda_oe;
		logic        sda_lvl;
		logic        addressed;
		logic        enable;
		logic        evt_en;
		logic        rx_flag;
		logic        tx_done;
		logic        tx_rst;
		logic [7:0]  rx_data;
		logic [7:0]  tx0;
		logic [7:0]  tx1;
		logic        irq;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} core_state_t;

	// State of the bus condition detector.
	typedef struct packed {
		logic scl_prev;
		logic sda_prev;
	} det_state_t;

endpackage : i2c_slave_pkg

// [src/bus_event_if.sv]
// Purpose: Carries the synchronised bus lines and their events to the slave core.
// Assumes: All signals are on pclk.
// Notes:   Events are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
interface bus_event_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;

	modport det  (output scl, sda, scl_rise, scl_fall, start, stop);
	modport core (input  scl, sda, scl_rise, scl_fall, start, stop);
endinterface : bus_event_if
`default_nettype wire

// [src/line_sync.sv]
// Purpose: Two-flop synchroniser for asynchronous input lines.
// Assumes: Inputs may change at any time relative to pclk.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/1ns
`default_nettype none
module line_sync #(
	parameter int W = 2
) (
	// Clock and reset.
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	// Lines.
	input  wire logic [W-1:0] d_async,
	output logic      [W-1:0] q_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;

	sync_state_t s_ff;
	sync_state_t nxt_s;

	// Lines idle high on the bus, so both stages reset to one.
	always_comb begin
		nxt_s = s_ff;
		if (ce) begin
			nxt_s.s1 = d_async;
			nxt_s.s2 = s_ff.s1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign q_sync = s_ff.s2;
endmodule : line_sync
`default_nettype wire

// [src/bus_cond_detect.sv]
// Purpose: Finds clock edges and start and stop conditions on the synchronised bus lines.
// Assumes: Lines arrive already synchronised to pclk.
// Notes:   Events are combinational pulses; the core registers what it uses.
`timescale 1ns/1ns
`default_nettype none
module bus_cond_detect
	import i2c_slave_pkg::*;
(
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// Synchronised lines.
	input  wire logic scl_s,
	input  wire logic sda_s,
	// Events to the core.
	bus_event_if.det  ev
);
	det_state_t s_ff;
	det_state_t nxt_s;

	// Remember the previous line levels.
	always_comb begin
		nxt_s = s_ff;
		if (ce) begin
			nxt_s.scl_prev = scl_s;
			nxt_s.sda_prev = sda_s;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Data edges while the clock stays high are start and stop.
	assign ev.scl      = scl_s;
	assign ev.sda      = sda_s;
	assign ev.scl_rise = ce & scl_s & ~s_ff.scl_prev;
	assign ev.scl_fall = ce & ~scl_s & s_ff.scl_prev;
	assign ev.start    = ce & scl_s & s_ff.scl_prev & s_ff.sda_prev & ~sda_s;
	assign ev.stop     = ce & scl_s & s_ff.scl_prev & ~s_ff.sda_prev & sda_s;
endmodule : bus_cond_detect
`default_nettype wire

// [src/i2c_slave_port.sv]
// Purpose: Fixed-address I2C slave port with APB register access.
// Assumes: pclk at least twice the bus clock; the master drives the clock line.
// Notes:   Receives bytes into a holding register, sends a two-byte message on reads.
//
// Contract
// - Slave only, answering the single fixed address whose write form is 0x6C.
// - When active, port line zero carries bus clock in, line one bidirectional data.
// - The data line is only pulled low, otherwise released to the pull-up.
// - The slave is active only while software sets its enable bit.
// - While enabled, internal pull-ups on both bus lines are switched on.
// - While enabled, the slave logic owns the direction of both bus pins.
// - After a start, eight bits are shifted in and compared with the address.
// - On a match the data line is held low during the ninth clock.
// - In writes every further byte is acknowledged low on its ninth clock.
// - A complete byte goes to the holding register and sets receive-ready.
// - Receive-ready stays set until software writes zero; software polls and clears.
// - Bytes keep being received and acknowledged until a stop condition.
// - With events enabled, each received byte raises an interrupt request.
// - Address bit zero selects direction; read form 0x6D makes the slave transmit.
// - Outgoing data comes from a buffer holding exactly two bytes.
// - After both message bytes are shifted out, transmit-done is set.
// - Transmit-done interrupt fires only while buffer reset status is clear; each finished pair sets it again.
// - System clock should run at least twice the bus clock.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "i2c_slave_regs.svh"
module i2c_slave_port
	import i2c_slave_pkg::*;
(
	// Clock, reset and freeze.
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Bus pins.
	input  wire logic        port_line_zero_i,
	input  wire logic        port_line_one_i,
	output logic             port_line_one_o,
	output logic             port_line_one_oe,
	// Pin control and events.
	output logic             pins_owned,
	output logic             pullup_en,
	output logic             event_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Line synchronisation and condition detection.

	logic [1:0] lines_s;

	bus_event_if ev ();

	// Clock line is bit one, data line bit zero.
	line_sync #(
		.W (2)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.d_async ({port_line_zero_i, port_line_one_i}),
		.q_sync  (lines_s)
	);

	bus_cond_detect u_det (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.scl_s   (lines_s[1]),
		.sda_s   (lines_s[0]),
		.ev      (ev.det)
	);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	core_state_t s_ff;
	core_state_t nxt_s;

	logic        apb_setup;
	logic        apb_write;
	logic        addr_ok;
	logic [31:0] rd_word;
	logic [7:0]  next_tx;

	// An access phase completes in the cycle after the setup phase.
	assign apb_setup = psel & ~penable & ~s_ff.pready;
	assign apb_write = psel & penable & s_ff.pready & pwrite & ~s_ff.pslverr;

	// Address decode, shared by read data and error answer.
	always_comb begin
		addr_ok = 1'b1;
		rd_word = `RST_WORD;
		case (paddr)
			`OFF_CTRL: begin
				rd_word[`CTL_ENABLE] = s_ff.enable;
				rd_word[`CTL_EVT_EN] = s_ff.evt_en;
			end
			`OFF_STATUS: begin
				rd_word[`ST_RX_READY]  = s_ff.rx_flag;
				rd_word[`ST_TX_DONE]   = s_ff.tx_done;
				rd_word[`ST_TX_RESET]  = s_ff.tx_rst;
				rd_word[`ST_ADDRESSED] = s_ff.addressed;
				rd_word[`ST_READ_DIR]  = s_ff.rw;
			end
			`OFF_DATA: begin
				rd_word[7:0] = s_ff.rx_data;
			end
			`OFF_TX0: begin
				rd_word[7:0] = s_ff.tx0;
			end
			`OFF_TX1: begin
				rd_word[7:0] = s_ff.tx1;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// Second message byte, or released filler once the pair is used up.
	assign next_tx = (s_ff.tx_cnt == `TXC_ONE) ? s_ff.tx1 : `TX_FILL;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Register writes come first so that a bus event in the same cycle wins over a clear.
	always_comb begin
		nxt_s = s_ff;
		if (ce) begin
			nxt_s.irq = 1'b0;

			// APB handshake: answer registered during the setup cycle.
			// The error answer stands exactly as long as pready, never past the access cycle.
			nxt_s.pready  = apb_setup;
			nxt_s.pslverr = apb_setup & ~addr_ok;
			if (apb_setup) begin
				nxt_s.prdata = rd_word;
			end

			// Register writes.
			if (apb_write) begin
				case (paddr)
					`OFF_CTRL: begin
						nxt_s.enable = pwdata[`CTL_ENABLE];
						nxt_s.evt_en = pwdata[`CTL_EVT_EN];
					end
					`OFF_STATUS: begin
						// Writing zero clears a flag; writing one leaves it alone.
						if (!pwdata[`ST_RX_READY]) begin
							nxt_s.rx_flag = 1'b0;
						end
						if (!pwdata[`ST_TX_DONE]) begin
							nxt_s.tx_done = 1'b0;
						end
						if (!pwdata[`ST_TX_RESET]) begin
							nxt_s.tx_rst = 1'b0;
						end
					end
					`OFF_TX0: begin
						nxt_s.tx0 = pwdata[7:0];
					end
					`OFF_TX1: begin
						nxt_s.tx1 = pwdata[7:0];
					end
					default: begin
						nxt_s.tx0 = s_ff.tx0;
					end
				endcase
			end

			// Bus sequencer. A disabled port releases the line and forgets the frame.
			// The new enable value is used so the line is freed in the same edge as ownership.
			if (!nxt_s.enable) begin
				nxt_s.st        = ST_IDLE;
				nxt_s.sda_oe    = 1'b0;
				nxt_s.addressed = 1'b0;
			end else if (ev.stop) begin
				nxt_s.st        = ST_IDLE;
				nxt_s.sda_oe    = 1'b0;
				nxt_s.addressed = 1'b0;
			end else if (ev.start) begin
				// A start, repeated or not, always restarts the address phase.
				nxt_s.st        = ST_ADDR;
				nxt_s.bitcnt    = 4'h0;
				nxt_s.sda_oe    = 1'b0;
				nxt_s.addressed = 1'b0;
			end else begin
				case (s_ff.st)
					ST_ADDR: begin
						if (ev.scl_rise) begin
							nxt_s.shreg  = {s_ff.shreg[6:0], ev.sda};
							nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
						end else if (ev.scl_fall && s_ff.bitcnt == `BITS_PER_BYTE) begin
							if ({s_ff.shreg[7:1], 1'b0} == `DEV_ADDR_WRITE) begin
								nxt_s.sda_oe    = 1'b1;
								nxt_s.rw        = s_ff.shreg[0];
								nxt_s.addressed = 1'b1;
								nxt_s.st        = ST_ADDR_ACK;
							end else begin
								nxt_s.st = ST_IGNORE;
							end
						end
					end
					ST_ADDR_ACK: begin
						// The ninth clock ends on its falling edge.
						if (ev.scl_fall) begin
							nxt_s.bitcnt = 4'h0;
							if (s_ff.rw) begin
								nxt_s.tx_cnt = `TXC_NONE;
								nxt_s.shreg  = s_ff.tx0;
								nxt_s.sda_oe = ~s_ff.tx0[7];
								nxt_s.st     = ST_TX;
							end else begin
								nxt_s.sda_oe = 1'b0;
								nxt_s.st     = ST_RX;
							end
						end
					end
					ST_RX: begin
						if (ev.scl_rise) begin
							nxt_s.shreg  = {s_ff.shreg[6:0], ev.sda};
							nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
						end else if (ev.scl_fall && s_ff.bitcnt == `BITS_PER_BYTE) begin
							nxt_s.rx_data = s_ff.shreg;
							nxt_s.rx_flag = 1'b1;
							nxt_s.irq     = s_ff.evt_en;
							nxt_s.sda_oe  = 1'b1;
							nxt_s.st      = ST_RX_ACK;
						end
					end
					ST_RX_ACK: begin
						if (ev.scl_fall) begin
							nxt_s.sda_oe = 1'b0;
							nxt_s.bitcnt = 4'h0;
							nxt_s.st     = ST_RX;
						end
					end
					ST_TX: begin
						if (ev.scl_rise) begin
							nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
						end else if (ev.scl_fall) begin
							if (s_ff.bitcnt == `BITS_PER_BYTE) begin
								// Byte out; let the master drive its acknowledge.
								nxt_s.sda_oe = 1'b0;
								nxt_s.st     = ST_TX_ACK;
								if (s_ff.tx_cnt == `TXC_NONE) begin
									nxt_s.tx_cnt = `TXC_ONE;
								end else if (s_ff.tx_cnt == `TXC_ONE) begin
									nxt_s.tx_cnt  = `TXC_TWO;
									nxt_s.tx_done = 1'b1;
									nxt_s.tx_rst  = 1'b1;
									nxt_s.irq     = s_ff.evt_en & ~s_ff.tx_rst;
								end
							end else begin
								// Next bit goes out while the clock is low.
								nxt_s.shreg  = {s_ff.shreg[6:0], 1'b1};
								nxt_s.sda_oe = ~s_ff.shreg[6];
							end
						end
					end
					ST_TX_ACK: begin
						if (ev.scl_rise) begin
							nxt_s.mack = ~ev.sda;
						end else if (ev.scl_fall) begin
							if (s_ff.mack) begin
								nxt_s.bitcnt = 4'h0;
								nxt_s.shreg  = next_tx;
								nxt_s.sda_oe = ~next_tx[7];
								nxt_s.st     = ST_TX;
							end else begin
								// A not-acknowledge ends the read; wait for stop or start.
								nxt_s.st = ST_IGNORE;
							end
						end
					end
					ST_IDLE, ST_IGNORE: begin
						nxt_s.sda_oe = 1'b0;
					end
					default: begin
						nxt_s.st     = ST_IDLE;
						nxt_s.sda_oe = 1'b0;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	// The buffer reset status starts set, so software must clear it before a read can raise an event.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '{
				st:        ST_IDLE,
				bitcnt:    4'h0,
				shreg:     `RST_BYTE,
				rw:        1'b0,
				tx_cnt:    `TXC_NONE,
				mack:      1'b0,
				sda_oe:    1'b0,
				sda_lvl:   1'b0,
				addressed: 1'b0,
				enable:    1'b0,
				evt_en:    1'b0,
				rx_flag:   1'b0,
				tx_done:   1'b0,
				tx_rst:    `RST_TX_RESET,
				rx_data:   `RST_BYTE,
				tx0:       `RST_BYTE,
				tx1:       `RST_BYTE,
				irq:       1'b0,
				pready:    1'b0,
				pslverr:   1'b0,
				prdata:    `RST_WORD
			};
		end else begin
			s_ff <= nxt_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register.

	// The data pin only ever drives low; its level flop never leaves zero.
	assign port_line_one_o  = s_ff.sda_lvl;
	assign port_line_one_oe = s_ff.sda_oe;
	assign pins_owned       = s_ff.enable;
	assign pullup_en        = s_ff.enable;
	assign event_irq        = s_ff.irq;
	assign prdata           = s_ff.prdata;
	assign pready           = s_ff.pready;
	assign pslverr          = s_ff.pslverr;

endmodule : i2c_slave_port
`default_nettype wire

// [verif/i2c_slave_port_chk.sv]
// Purpose: Port-level assertions for the I2C slave port.
// Assumes: One pclk domain, presetn asynchronous and active low.
// Notes:   Attached by bind; sees only the top module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "i2c_slave_regs.svh"
module i2c_slave_port_chk (
	// Clock and reset.
	input wire logic        pclk,
	input wire logic        presetn,
	// Register bus.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins and events.
	input wire logic        port_line_zero_i,
	input wire logic        port_line_one_o,
	input wire logic        port_line_one_oe,
	input wire logic        pins_owned,
	input wire logic        pullup_en,
	input wire logic        event_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////////////
	// Pin ownership and drive strength.
	chk_pull_low_only: assert property (port_line_one_oe |-> !port_line_one_o)
		else $error("data line driven high");
	chk_oe_needs_enable: assert property (port_line_one_oe |-> pins_owned)
		else $error("data line driven while disabled");
	// Two edges of slack cover a registered copy of the enable bit.
	chk_enable_write: assert property ((psel && penable && pready && pwrite && paddr == `OFF_CTRL)
		|=> ##1 (pins_owned == $past(pwdata[0], 2)))
		else $error("pin ownership does not follow enable");
	chk_pullup_owner: assert property (pullup_en == pins_owned)
		else $error("pull-ups differ from ownership");

	////////////////////////////////////////////////////////////////////////////////
	// Bus timing: a low drive lasts at least eight cycles and moves only while the clock is low.
	chk_ack_held: assert property ($rose(port_line_one_oe) |-> port_line_one_oe[*8])
		else $error("low drive released too early");
	chk_oe_clock_low: assert property ($changed(port_line_one_oe) |-> !port_line_zero_i)
		else $error("data line moved while clock high");
	chk_irq_single: assert property (event_irq |=> !event_irq)
		else $error("event pulse longer than one cycle");

	////////////////////////////////////////////////////////////////////////////////
	// Register bus answers.
	chk_apb_zero_wait: assert property ((psel && !penable && !pready) |=> pready)
		else $error("register access not answered at once");
	chk_err_pairs: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule : i2c_slave_port_chk

bind i2c_slave_port i2c_slave_port_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .port_line_zero_i(port_line_zero_i), .port_line_one_o(port_line_one_o),
	.port_line_one_oe(port_line_one_oe), .pins_owned(pins_owned), .pullup_en(pullup_en),
	.event_irq(event_irq));
`default_nettype wire

// [verif/i2c_bus_master.sv]
// Purpose: Behavioural I2C bus master driving the clock and pulling data low.
// Assumes: The data line has a pull-up; 125 ns bit slot.
// Notes:   The clock stands high between frames and low between calls inside one.
`timescale 1ns/1ns
`default_nettype none
module i2c_bus_master (
	// Bus lines.
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	// Idle bus: both lines released.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One bit slot; slow enough for a slave sampling at 100 MHz.
	task automatic bit_slot(input logic b, output logic got);
		sda_low = ~b;
		#31;
		scl = 1'b1;
		#31;
		got = sda;
		#31;
		scl = 1'b0;
		#32;
	endtask : bit_slot

	// Start: data falls while the clock is high.
	task automatic start;
		sda_low = 1'b1;
		#62;
		scl = 1'b0;
		#32;
	endtask : start

	// Stop: data rises while the clock is high.
	task automatic stop;
		sda_low = 1'b1;
		#31;
		scl = 1'b1;
		#31;
		sda_low = 1'b0;
		#63;
	endtask : stop

	// Byte out, most significant bit first, then the slave's answer.
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(b[i], g);
		end
		bit_slot(1'b1, g);
		ack = ~g;
	endtask : put_byte

	// Byte in; the master acknowledges unless this is the last byte.
	task automatic get_byte(input logic ack, output logic [7:0] b);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'b1, b[i]);
		end
		bit_slot(~ack, g);
	endtask : get_byte
endmodule : i2c_bus_master
`default_nettype wire

// [verif/i2c_slave_fixed_address_bench.sv]
// Purpose: Self-checking bench for the I2C slave port.
// Assumes: pclk 100 MHz; a behavioural master on the bus pins.
// Notes:   Registers are reached over APB tasks; bus traffic through the master model.
`timescale 1ns/1ns
`default_nettype none
`include "i2c_slave_regs.svh"
module i2c_slave_fixed_address_bench;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat, n_irq;
	logic        pready, pslverr, rerr, line_o, line_oe, pins_owned, pullup_en, event_irq;
	logic        scl, sda_low, ack;
	logic [7:0]  rb;
	wire         sda_bus;
	int          mismatches, n_checks;

	// Pull-up wins unless someone pulls low; a driven slave shows its output level.
	assign sda_bus = sda_low ? 1'b0 : (line_oe ? line_o : 1'b1);

	i2c_slave_port u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_line_zero_i(scl), .port_line_one_i(sda_bus), .port_line_one_o(line_o),
		.port_line_one_oe(line_oe), .pins_owned(pins_owned), .pullup_en(pullup_en), .event_irq(event_irq));
	i2c_bus_master u_mst (.scl(scl), .sda_low(sda_low), .sda(sda_bus));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, event counter and hang guard.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (event_irq === 1'b1) n_irq <= n_irq + 32'h1;
	end
	initial begin
		repeat (100000) @(posedge pclk);
		mismatches++;
		close_out;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tasks.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// Request held until pready is seen high at an edge; data taken there.
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (pready !== 1'b1) begin
			mismatches++;
			close_out;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		check(rdat & m, e);
	endtask : rd

	task automatic close_out;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_irq = 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rd(`OFF_CTRL, 32'hFFFFFFFF, 32'h0);
		rd(`OFF_STATUS, 32'h7, 32'h4);
		xfer(8'h14, 1'b0, 32'h0);
		check({31'h0, rerr}, 32'h1);
		u_mst.start;
		u_mst.put_byte(8'h6C, ack);
		u_mst.stop;
		check({31'h0, ack}, 32'h0);
		xfer(`OFF_CTRL, 1'b1, 32'h3);
		// The enable flop updates at the access edge; look one edge later.
		@(posedge pclk);
		check({30'h0, pins_owned, pullup_en}, 32'h3);
		// Two bytes written back to back, flag left set between them.
		u_mst.start;
		u_mst.put_byte(8'h6C, ack);
		check({31'h0, ack}, 32'h1);
		u_mst.put_byte(8'hA5, ack);
		check({31'h0, ack}, 32'h1);
		rd(`OFF_DATA, 32'hFF, 32'hA5);
		rd(`OFF_STATUS, 32'h1, 32'h1);
		u_mst.put_byte(8'h3C, ack);
		check({31'h0, ack}, 32'h1);
		rd(`OFF_DATA, 32'hFF, 32'h3C);
		u_mst.stop;
		xfer(`OFF_STATUS, 1'b1, 32'h6);
		rd(`OFF_STATUS, 32'h7, 32'h4);
		check(n_irq, 32'h2);
		// Foreign address: no answer, data ignored.
		u_mst.start;
		u_mst.put_byte(8'h6E, ack);
		check({31'h0, ack}, 32'h0);
		u_mst.put_byte(8'h11, ack);
		check({31'h0, ack}, 32'h0);
		u_mst.stop;
		rd(`OFF_DATA, 32'hFF, 32'h3C);
		// Two-byte message read after reset status is cleared.
		xfer(`OFF_STATUS, 1'b1, 32'h0);
		xfer(`OFF_TX0, 1'b1, 32'h96);
		xfer(`OFF_TX1, 1'b1, 32'h5A);
		u_mst.start;
		u_mst.put_byte(8'h6D, ack);
		check({31'h0, ack}, 32'h1);
		u_mst.get_byte(1'b1, rb);
		check({24'h0, rb}, 32'h96);
		rd(`OFF_STATUS, 32'h2, 32'h0);
		u_mst.get_byte(1'b0, rb);
		check({24'h0, rb}, 32'h5A);
		u_mst.stop;
		rd(`OFF_STATUS, 32'h7, 32'h6);
		check(n_irq, 32'h3);
		// Second pair without clearing reset status: done again, no event.
		xfer(`OFF_STATUS, 1'b1, 32'h4);
		u_mst.start;
		u_mst.put_byte(8'h6D, ack);
		u_mst.get_byte(1'b1, rb);
		u_mst.get_byte(1'b0, rb);
		u_mst.stop;
		rd(`OFF_STATUS, 32'h7, 32'h6);
		check(n_irq, 32'h3);
		xfer(`OFF_CTRL, 1'b1, 32'h0);
		@(posedge pclk);
		check({30'h0, pins_owned, pullup_en}, 32'h0);
		close_out;
	end
endmodule : i2c_slave_fixed_address_bench
`default_nettype wire
